/* File: hdl/cpualu_defs.svh */
// What this block does
// - decrement: carry cleared when result is hFF
// - decrement with borrow: carry clear on hFF, Cin=0
// - and/or/xor update zero only, keep C,V
// - immediate, three-reg, two-reg, memory operand forms
// - add: carry set on ninth bit
// - add with carry adds incoming carry
// - reverse difference: carry means no borrow
// - reverse difference with borrow subtracts one minus carry
// - forward difference: carry cleared on underflow
// - forward difference with borrow, same carry rule
// - multiply: low byte acc, high byte dest
// - scaled multiply by two to shift power
// - compare writes acc only, V = C and not Z
// - bit probe keeps selected bit, zeros others
// - bit set/clear/flip, acc gets updated register
// - memory operand read with index update same instruction
`ifndef CPUALU_DEFS_SVH
`define CPUALU_DEFS_SVH
`define CPUALU_DEC_WRAP      8'hff
`define CPUALU_MSH_BASE      4'h8
`define CPUALU_FLAGS_RST     3'h0
`define CPUALU_ACC_RST       8'h00
`endif

/* File: hdl/cpualu_pkg.sv */
package cpualu_pkg;
  typedef enum logic [4:0] {
    CPUALU_NOP   = 5'h00,
    CPUALU_DEC   = 5'h01,
    CPUALU_DECC  = 5'h02,
    CPUALU_AND   = 5'h03,
    CPUALU_OR    = 5'h04,
    CPUALU_XOR   = 5'h05,
    CPUALU_ADD   = 5'h06,
    CPUALU_ADDC  = 5'h07,
    CPUALU_SUBD  = 5'h08,
    CPUALU_SUBDC = 5'h09,
    CPUALU_SUBS  = 5'h0a,
    CPUALU_SUBSC = 5'h0b,
    CPUALU_MUL   = 5'h0c,
    CPUALU_MULA  = 5'h0d,
    CPUALU_MSHL  = 5'h0e,
    CPUALU_MSHR  = 5'h0f,
    CPUALU_MSHRA = 5'h10,
    CPUALU_CMP   = 5'h11,
    CPUALU_CMPA  = 5'h12,
    CPUALU_TSTB  = 5'h13,
    CPUALU_SETB  = 5'h14,
    CPUALU_CLRB  = 5'h15,
    CPUALU_INVB  = 5'h16
  } cpualu_op_t;

  // operand form selects which source feeds which side
  typedef enum logic [1:0] {
    CPUALU_F_IMM  = 2'b00,
    CPUALU_F_REG3 = 2'b01,
    CPUALU_F_REG2 = 2'b10,
    CPUALU_F_MEM  = 2'b11
  } cpualu_form_t;

  typedef struct packed {
    logic         valid;
    cpualu_op_t   op;
    cpualu_form_t form;
    logic [7:0]   reg1;
    logic [7:0]   reg2;
    logic [7:0]   reg3;
    logic [7:0]   imm;
    logic [7:0]   memData;
  } cpualu_req_t;

  typedef struct packed {
    logic       accWe;
    logic [7:0] acc;
    logic       dstWe;
    logic [7:0] dst;
    logic       idxUpd;
  } cpualu_res_t;

  typedef struct packed {
    logic c;
    logic v;
    logic z;
  } cpualu_flags_t;
endpackage

/* File: hdl/cpualu_core.sv */
`timescale 1ns/1ps
`include "cpualu_defs.svh"
module cpualu_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // request from decoder and register file
  input  wire cpualu_pkg::cpualu_req_t req,
  // results to register file
  output cpualu_pkg::cpualu_res_t   res,
  output cpualu_pkg::cpualu_flags_t flags
);
  import cpualu_pkg::*;

  // a = x - y - (1 - cin), returns {noBorrow, diff}
  function automatic logic [8:0] subFn(input logic [7:0] x, input logic [7:0] y, input logic cin);
    logic [8:0] t;
    t = {1'b0, x} + {1'b0, ~y} + {8'h00, cin};
    return t;
  endfunction

  function automatic logic subOvf(input logic [7:0] x, input logic [7:0] y, input logic [7:0] r);
    return (x[7] != y[7]) && (r[7] != x[7]);
  endfunction

  // compare forms write only the accumulator
  function automatic logic isCmp(input cpualu_op_t o);
    return (o == CPUALU_CMP) || (o == CPUALU_CMPA);
  endfunction

  // true multiply; the scaled forms reuse the product bus
  function automatic logic isMul(input cpualu_op_t o);
    return (o == CPUALU_MUL) || (o == CPUALU_MULA);
  endfunction

  // product-style ops leave every flag as it was
  function automatic logic isProd(input cpualu_op_t o);
    return isMul(o) || (o == CPUALU_MSHL) || (o == CPUALU_MSHR) || (o == CPUALU_MSHRA);
  endfunction

  cpualu_res_t   res_r, res_nxt;
  cpualu_flags_t flags_r, flags_nxt;

  cpualu_op_t op;
  wire logic c;
  assign op = req.op;
  assign c  = flags_r.c;

  // op classes decoded once and shared by datapath and flag logic
  wire logic cmpOp;
  wire logic mulOp;
  wire logic prodOp;
  wire logic decBorrowIn;
  wire logic nopOp;
  wire logic zeroUpd;
  wire logic memTaken;
  assign cmpOp       = isCmp(op);
  assign mulOp       = isMul(op);
  assign prodOp      = isProd(op);
  assign decBorrowIn = (op == CPUALU_DECC) & c;
  assign nopOp       = (op == CPUALU_NOP);
  assign zeroUpd     = !nopOp && !prodOp;
  // a no-operation never moves an index register, even in memory form
  assign memTaken    = req.valid && (req.form == CPUALU_F_MEM) && !nopOp;

  // operand selection per form; memory data arrives already fetched
  wire logic [7:0] srcA;
  wire logic [7:0] srcB;
  assign srcA = (req.form == CPUALU_F_REG3) ? req.reg2 :
                (req.form == CPUALU_F_REG2) ? req.reg1 : req.reg1;
  assign srcB = (req.form == CPUALU_F_IMM)  ? req.imm :
                (req.form == CPUALU_F_REG3) ? req.reg3 :
                (req.form == CPUALU_F_REG2) ? req.reg2 : req.memData;

  // forward difference: reg - other; three-register form is reg3 - reg2
  wire logic [7:0] fwdX;
  wire logic [7:0] fwdY;
  assign fwdX = (req.form == CPUALU_F_REG3) ? req.reg3 : srcA;
  assign fwdY = (req.form == CPUALU_F_REG3) ? req.reg2 : srcB;
  // reverse difference: other - reg; three-register form is reg2 - reg3
  wire logic [7:0] revX;
  wire logic [7:0] revY;
  assign revX = (req.form == CPUALU_F_REG3) ? req.reg2 : srcB;
  assign revY = (req.form == CPUALU_F_REG3) ? req.reg3 : srcA;

  // borrow variants feed the incoming carry; plain ones feed one
  wire logic withCarry;
  assign withCarry = (op == CPUALU_ADDC) || (op == CPUALU_SUBDC) || (op == CPUALU_SUBSC) || (op == CPUALU_DECC);
  wire logic cin;
  assign cin = withCarry ? c : 1'b1;

  wire logic [8:0] addSum;
  assign addSum = {1'b0, srcA} + {1'b0, srcB} + {8'h00, (op == CPUALU_ADDC) & c};
  wire logic       addOvf;
  assign addOvf = (srcA[7] == srcB[7]) && (addSum[7] != srcA[7]);

  wire logic [8:0] fwdRes;
  wire logic [8:0] revRes;
  assign fwdRes = subFn(fwdX, fwdY, cin);
  assign revRes = subFn(revX, revY, cmpOp ? 1'b1 : cin);
  // compare overflow means no borrow and a nonzero difference
  wire logic       cmpOvf;
  assign cmpOvf = revRes[8] && (revRes[7:0] != 8'h00);

  // decrement operand: reg2 in register forms, memory in memory form, reg1 in immediate form
  wire logic [7:0] decSrc;
  wire logic [7:0] decRes;
  assign decSrc = (req.form == CPUALU_F_MEM) ? req.memData :
                  (req.form == CPUALU_F_REG3 || req.form == CPUALU_F_REG2) ? req.reg2 : req.reg1;
  assign decRes = decSrc - {7'h00, ~decBorrowIn};
  wire logic       decCarry;
  wire logic       decOvf;
  assign decCarry = !((decRes == `CPUALU_DEC_WRAP) && !decBorrowIn);
  assign decOvf   = subOvf(decSrc, 8'h01, decRes) && !decBorrowIn;

  // multiply and scaled multiply share one product bus; only multiply uses the 8x8 product
  wire logic [3:0]  mshAmt;
  wire logic [7:0]  mulB;
  wire logic [15:0] prod;
  assign mshAmt = (op == CPUALU_MSHL) ? {1'b0, req.imm[2:0]} : (`CPUALU_MSH_BASE - {1'b0, req.imm[2:0]});
  assign mulB   = mulOp ? srcB : 8'h00;
  // 2^8 does not fit a byte, so scaled forms use a shift rather than the multiplier
  assign prod   = mulOp ? (srcA * mulB)
                        : ({8'h00, req.reg1} << mshAmt);

  wire logic [2:0] bitIdx;
  wire logic [7:0] bitMask;
  assign bitIdx  = req.imm[2:0];
  assign bitMask = 8'h01 << bitIdx;

  // bitwise result and bit-modified register, both go to acc and dst
  wire logic [7:0] logicRes;
  wire logic [7:0] bitRes;
  assign logicRes = (op == CPUALU_AND) ? (srcA & srcB) :
                    (op == CPUALU_OR)  ? (srcA | srcB) : (srcA ^ srcB);
  assign bitRes   = (op == CPUALU_SETB) ? (req.reg1 | bitMask) :
                    (op == CPUALU_CLRB) ? (req.reg1 & ~bitMask) : (req.reg1 ^ bitMask);

  // flags hold unless the op updates them; res is a one-cycle pulse
  always_comb
  begin
    res_nxt        = '0;
    flags_nxt      = flags_r;
    res_nxt.idxUpd = memTaken;
    if (req.valid)
    begin
      unique case (op)
        CPUALU_DEC, CPUALU_DECC:
        begin
          res_nxt.acc = decRes;
          res_nxt.dst = decRes;
          flags_nxt.c = decCarry;
          flags_nxt.v = decOvf;
        end
        CPUALU_AND, CPUALU_OR, CPUALU_XOR:
        begin
          res_nxt.acc = logicRes;
          res_nxt.dst = res_nxt.acc;
        end
        CPUALU_ADD, CPUALU_ADDC:
        begin
          res_nxt.acc = addSum[7:0];
          res_nxt.dst = addSum[7:0];
          flags_nxt.c = addSum[8];
          flags_nxt.v = addOvf;
        end
        CPUALU_SUBD, CPUALU_SUBDC, CPUALU_CMP, CPUALU_CMPA:
        begin
          res_nxt.acc = revRes[7:0];
          res_nxt.dst = revRes[7:0];
          flags_nxt.c = revRes[8];
          flags_nxt.v = subOvf(revX, revY, revRes[7:0]);
          if (cmpOp)
            flags_nxt.v = cmpOvf;
        end
        CPUALU_SUBS, CPUALU_SUBSC:
        begin
          res_nxt.acc = fwdRes[7:0];
          res_nxt.dst = fwdRes[7:0];
          flags_nxt.c = fwdRes[8];
          flags_nxt.v = subOvf(fwdX, fwdY, fwdRes[7:0]);
        end
        CPUALU_MUL, CPUALU_MULA, CPUALU_MSHL, CPUALU_MSHR, CPUALU_MSHRA:
        begin
          res_nxt.acc = prod[7:0];
          res_nxt.dst = prod[15:8];
        end
        CPUALU_TSTB:
          res_nxt.acc = req.reg1 & bitMask;
        CPUALU_SETB, CPUALU_CLRB, CPUALU_INVB:
        begin
          res_nxt.dst = bitRes;
          res_nxt.acc = res_nxt.dst;
        end
        default:
        begin
          res_nxt.acc = `CPUALU_ACC_RST;
        end
      endcase
      res_nxt.accWe = !nopOp;
      res_nxt.dstWe = !(nopOp || cmpOp || (op == CPUALU_TSTB));
      // multiply leaves flags undefined; keeping them is cheap and predictable
      if (zeroUpd)
        flags_nxt.z = (res_nxt.acc == 8'h00);
    end
  end

  // synchronous reset drops any request sampled on the same edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      res_r   <= '0;
      flags_r <= `CPUALU_FLAGS_RST;
    end
    else
    begin
      res_r   <= res_nxt;
      flags_r <= flags_nxt;
    end
  end

  assign res   = res_r;
  assign flags = flags_r;
endmodule

/* File: bench/cpualu_core_props.sv */
`timescale 1ns/1ps
module cpualu_core_props (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst_b,
  // watched ports
  input wire cpualu_pkg::cpualu_req_t   req,
  input wire cpualu_pkg::cpualu_res_t   res,
  input wire cpualu_pkg::cpualu_flags_t flags
);
  import cpualu_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence sAddImm;
    req.valid && req.op == CPUALU_ADD && req.form == CPUALU_F_IMM;
  endsequence
  sequence sDecImm;
    req.valid && req.op == CPUALU_DEC && req.form == CPUALU_F_IMM;
  endsequence
  AST_DEC_CARRY: assert property (sDecImm |=> res.acc == $past(req.reg1) - 8'h01 && flags.c == (res.acc != 8'hff))
    else $error("decrement result or carry wrong");
  AST_LOGIC_KEEPS_CV: assert property (req.valid && req.op inside {CPUALU_AND, CPUALU_OR, CPUALU_XOR} |=> $stable(flags[2:1]))
    else $error("logic op changed carry or overflow");
  AST_ADD_SUM: assert property (sAddImm |=> {flags.c, res.acc} == 9'($past(req.reg1)) + 9'($past(req.imm)))
    else $error("add sum or carry wrong");
  AST_MUL_SPLIT: assert property (req.valid && req.op == CPUALU_MUL && req.form == CPUALU_F_REG2
    |=> {res.dst, res.acc} == 16'($past(req.reg1)) * 16'($past(req.reg2)))
    else $error("product bytes wrong");
  AST_CMP_FLAGS: assert property (req.valid && req.op == CPUALU_CMP |=> !res.dstWe && flags.v == (flags.c && !flags.z))
    else $error("compare wrote destination or bad overflow");
  AST_PROBE_BIT: assert property (req.valid && req.op == CPUALU_TSTB
    |=> res.acc == ($past(req.reg1) & (8'h01 << $past(req.imm[2:0]))))
    else $error("bit probe result wrong");
  AST_MEM_INDEX: assert property (req.valid && req.op == CPUALU_AND && req.form == CPUALU_F_MEM |=> res.idxUpd)
    else $error("memory form without index update");
  AST_ZERO_FLAG: assert property (req.valid && req.op inside {[CPUALU_DEC:CPUALU_SUBSC], [CPUALU_CMP:CPUALU_INVB]}
    |=> flags.z == (res.acc == 8'h00))
    else $error("zero flag disagrees with result");
  AST_IDLE_QUIET: assert property (!req.valid || req.op == CPUALU_NOP
    |=> !res.accWe && !res.dstWe && !res.idxUpd && $stable(flags))
    else $error("idle or no-operation cycle wrote a result or moved flags");
endmodule
bind cpualu_core cpualu_core_props u_props (.clk(clk), .rst_b(rst_b), .req(req), .res(res), .flags(flags));

/* File: bench/cpualu_decoder.sv */
`timescale 1ns/1ps
module cpualu_decoder (
  // command from the bench
  input wire cpualu_pkg::cpualu_req_t cmd,
  // request into the unit
  output cpualu_pkg::cpualu_req_t     req
);
  import cpualu_pkg::*;
  // idle cycles carry scrambled operands so stale values cannot pass as valid
  assign req = cmd.valid ? cmd : {1'b0, ~cmd[$bits(cmd)-2:0]};
endmodule

/* File: bench/cpu_alu_operation_set_test.sv */
`timescale 1ns/1ps
module cpu_alu_operation_set_test;
  import cpualu_pkg::*;
  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  cpualu_req_t   cmd = '0;
  cpualu_req_t   req;
  cpualu_res_t   res;
  cpualu_flags_t flags;
  int            errors = 0;
  int            checks_done = 0;
  int            cycles = 0;
  int            mc, mv, mz;
  cpualu_req_t   q;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      give_verdict();
    end
  end
  cpualu_decoder partner (.cmd(cmd), .req(req));
  cpualu_core dut (.clk(clk), .rst_b(rst_b), .req(req), .res(res), .flags(flags));
  task automatic give_verdict();
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input int exp);
    checks_done++;
    if (got !== 16'(exp))
    begin
      errors++;
      $display("Error %0t got %h exp %h", $time, got, 16'(exp));
    end
  endtask
  function automatic int sg(int x);
    return x > 127 ? x - 256 : x;
  endfunction
  function automatic logic [7:0] rv();
    case ($urandom % 4)
      0: return 8'h00;
      1: return 8'hff;
      2: return 8'h80;
      default: return 8'($urandom);
    endcase
  endfunction
  // one request per cycle; model reckons the result while the unit works
  task automatic step(input cpualu_req_t t);
    int a, b, x, y, s, bw, r, sv, p, k, acc, dst, dw;
    cmd = t;
    @(negedge clk);
    a = t.form == CPUALU_F_REG3 ? t.reg2 : t.reg1;
    b = t.form == CPUALU_F_IMM ? t.imm : t.form == CPUALU_F_REG3 ? t.reg3 : t.form == CPUALU_F_REG2 ? t.reg2 : t.memData;
    x = b; y = a; s = -1; bw = 0; k = 2; dw = 1; p = 0; r = 0;
    case (t.op)
      CPUALU_DEC, CPUALU_DECC: begin x = t.form == CPUALU_F_IMM ? t.reg1 : t.form == CPUALU_F_MEM ? t.memData : t.reg2;
        y = 0; bw = t.op == CPUALU_DEC ? 1 : 1 - mc; end
      CPUALU_ADD, CPUALU_ADDC: begin x = a; y = b; s = 1; bw = t.op == CPUALU_ADDC ? mc : 0; end
      CPUALU_SUBD, CPUALU_SUBDC, CPUALU_CMP, CPUALU_CMPA: begin
        if (t.form == CPUALU_F_REG3) begin x = t.reg2; y = t.reg3; end
        bw = t.op == CPUALU_SUBDC ? 1 - mc : 0; dw = t.op inside {CPUALU_CMP, CPUALU_CMPA} ? 0 : 1; end
      CPUALU_SUBS, CPUALU_SUBSC: begin x = t.form == CPUALU_F_REG3 ? t.reg3 : a;
        y = t.form == CPUALU_F_REG3 ? t.reg2 : b; bw = t.op == CPUALU_SUBSC ? 1 - mc : 0; end
      CPUALU_AND: begin k = 1; r = a & b; end
      CPUALU_OR: begin k = 1; r = a | b; end
      CPUALU_XOR: begin k = 1; r = a ^ b; end
      CPUALU_MUL, CPUALU_MULA: begin k = 0; p = a * b; end
      CPUALU_MSHL: begin k = 0; p = t.reg1 << t.imm[2:0]; end
      CPUALU_MSHR, CPUALU_MSHRA: begin k = 0; p = t.reg1 << (8 - t.imm[2:0]); end
      CPUALU_TSTB: begin k = 1; dw = 0; r = t.reg1 & (1 << t.imm[2:0]); end
      CPUALU_SETB: begin k = 1; r = t.reg1 | (1 << t.imm[2:0]); end
      CPUALU_CLRB: begin k = 1; r = t.reg1 & ~(1 << t.imm[2:0]); end
      default: begin k = 1; r = t.reg1 ^ (1 << t.imm[2:0]); end
    endcase
    if (k == 2) r = x + s * (y + bw);
    sv = sg(x) + s * (sg(y) + bw);
    acc = k == 0 ? p & 255 : r & 255;
    dst = k == 0 ? (p >> 8) & 255 : acc;
    if (!t.valid || t.op == CPUALU_NOP)
    begin
      k = 3;
      acc = 0;
      dst = 0;
    end
    if (k == 1 || k == 2) mz = acc == 0;
    if (k == 2) mc = s > 0 ? r > 255 : r >= 0;
    if (k == 2) mv = dw == 0 ? mc && !mz : sv < -128 || sv > 127;
    cmp({res.accWe, res.dstWe, res.idxUpd}, k < 3 ? 4 + dw * 2 + (t.form == CPUALU_F_MEM) : 0);
    cmp(res.acc, acc);
    if (dw == 1) cmp(res.dst, dst);
    cmp({flags.c, flags.v, flags.z}, mc * 4 + mv * 2 + mz);
  endtask
  initial
  begin
    mc = 0; mv = 0; mz = 0;
    void'($urandom(10063));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    q = '0; q.valid = 1'b1; q.op = CPUALU_ADD; q.reg1 = 8'hff; q.imm = 8'h01;
    step(q);
    for (int i = 0; i < 2000; i++)
    begin
      if (i == 1000)
      begin
        rst_b = 1'b0; cmd = '0;
        @(negedge clk);
        cmp({res.accWe, res.dstWe, res.idxUpd, flags, res.acc}, 0);
        cmp(res.dst, 0);
        rst_b = 1'b1; mc = 0; mv = 0; mz = 0;
      end
      q.valid = ($urandom % 8) != 0;
      q.op = cpualu_op_t'($urandom % 23);
      q.form = cpualu_form_t'($urandom % 4);
      if (q.op inside {[CPUALU_MSHL:CPUALU_MSHRA], [CPUALU_TSTB:CPUALU_INVB]}) q.form = CPUALU_F_IMM;
      if (q.op inside {CPUALU_CMP, CPUALU_CMPA} && q.form == CPUALU_F_REG3) q.form = CPUALU_F_REG2;
      q.reg1 = rv(); q.reg2 = rv(); q.reg3 = rv(); q.imm = rv(); q.memData = rv();
      step(q);
    end
    give_verdict();
  end
endmodule
